//--- wd_pkg.sv
// Constants and types shared by the watchdog files
package wd_pkg;
  localparam int unsigned    APB_AW             = 8;
  localparam int unsigned    APB_DW             = 32;
  localparam int unsigned    PRESCALE_W         = 13;
  localparam int unsigned    COUNT_W            = 8;
  localparam int unsigned    SEL_W              = 3;
  localparam int unsigned    TAP_BASE           = 5;
  localparam int unsigned    TAP_NUM            = 8;
  localparam logic [7:0]     OFS_CONTROL        = 8'h00;
  localparam logic [7:0]     OFS_RELOAD         = 8'h04;
  localparam logic [7:0]     OFS_FEED_FIRST     = 8'h08;
  localparam logic [7:0]     OFS_FEED_SECOND    = 8'h0C;
  localparam logic [7:0]     OFS_STATUS         = 8'h10;
  localparam logic [7:0]     OFS_PENDING        = 8'h14;
  localparam int unsigned    SEL_HI             = 7;
  localparam int unsigned    SEL_LO             = 5;
  localparam int unsigned    RUN_BIT            = 2;
  localparam int unsigned    TOF_BIT            = 1;
  localparam int unsigned    STAT_PRE_LO        = 8;
  localparam int unsigned    STAT_ARMED_BIT     = 24;
  localparam logic [7:0]     KEY_FIRST          = 8'hA5;
  localparam logic [7:0]     KEY_SECOND         = 8'h5A;
  localparam logic [2:0]     SEL_RESET          = 3'h7;
  localparam logic           RUN_RESET          = 1'b1;
  localparam logic [7:0]     RELOAD_RESET       = 8'h00;
  localparam logic [7:0]     CONTROL_WMASK      = 8'hE4;
  localparam int unsigned    CLK_PERIOD_PS      = 4000;
  localparam int unsigned    RESET_PULSE_NS     = 16;
  localparam int unsigned    RESET_PULSE_CYCLES = (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0]     RESET_PULSE_CNT    = 4'(RESET_PULSE_CYCLES);

  typedef enum logic {
    FEED_IDLE,
    FEED_ARMED
  } feed_state_t;
endpackage

//--- wd_prescaler.sv
// Watchdog prescaler with selectable decrement tap
`timescale 1ns/1ps
module wd_prescaler
  import wd_pkg::*;
#(
  parameter int unsigned WIDTH = PRESCALE_W
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             tick,
  input  wire logic             run,
  input  wire logic             clear,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  tap_pulse,
  output logic [WIDTH-1:0]      count
);
  logic [WIDTH-1:0]   count_q;
  logic [WIDTH-1:0]   count_d;
  logic [TAP_NUM-1:0] tap_hit;

  // Tap i fires every 32 * 2**i ticks
  for (genvar i = 0; i < TAP_NUM; i++) begin : g_tap
    assign tap_hit[i] = &count_q[TAP_BASE+i-1:0]; // RQ5 RQ15
  end

  assign tap_pulse = tick & run & tap_hit[sel]; // RQ5 RQ25
  assign count_d   = clear ? '0 : ((tick & run) ? count_q + 1'b1 : count_q); // RQ4 RQ7 RQ25
  assign count     = count_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0; // RQ18
    end else begin
      count_q <= count_d;
    end
  end
endmodule

//--- wd_feed_guard.sv
// Two-write feed key sequence checker
`timescale 1ns/1ps
module wd_feed_guard
  import wd_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       access,
  input  wire logic       write,
  input  wire logic       hit_first,
  input  wire logic       hit_second,
  input  wire logic [7:0] wdata,
  output logic            feed_ok,
  output logic            feed_fault,
  output logic            armed
);
  feed_state_t state_q;
  feed_state_t state_d;
  logic        first_ok;
  logic        second_ok;

  assign first_ok  = access & write & hit_first & (wdata == KEY_FIRST);
  assign second_ok = access & write & hit_second & (wdata == KEY_SECOND);

  always_comb begin
    state_d    = state_q;
    feed_ok    = 1'b0;
    feed_fault = 1'b0;
    case (state_q)
      FEED_IDLE: begin
        if (first_ok) begin
          state_d = FEED_ARMED; // RQ10
        end
      end
      FEED_ARMED: begin
        if (access) begin
          state_d    = FEED_IDLE;
          feed_ok    = second_ok; // RQ10
          feed_fault = ~second_ok; // RQ11 RQ12
        end
      end
      default: begin
        state_d = FEED_IDLE;
      end
    endcase
  end

  assign armed = (state_q == FEED_ARMED);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= FEED_IDLE;
    end else begin
      state_q <= state_d;
    end
  end
endmodule

//--- watchdog_feed_reset_timer.sv
// Watchdog timer with feed keys, APB register access and reset request
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Operation
// RQ1: Counter underflow forces a full system reset request.
// RQ2: Watchdog runs after any reset until software disables it.
// RQ3: A 13-bit prescaler feeds an 8-bit down-counter.
// RQ4: Prescaler counts timer tick clock pulses.
// RQ5: Counter decrements on each pulse of a selected upper prescaler tap.
// RQ6: Decrement at zero is underflow and reloads from the autoload register.
// RQ7: Every autoload clears the prescaler; any reload value including zero.
// RQ8: Time-out equals tick period times divisor times reload plus one.
// RQ9: Counter is never written directly, only loaded by feed or underflow.
// RQ10: Writing A5 to first key then 5A to second key feeds.
// RQ11: Any other access between the two key writes forces reset.
// RQ12: Wrong value to second key after correct first forces reset.
// RQ13: Control writes stay pending until a valid feed commits them.
// RQ14: Software disables by writing zero to control, then feeding.
// RQ15: Select field picks divisor 32 times two to the field.
// RQ16: Reset values give a running watchdog with a 4096-tick time-out.
// RQ17: External reset sets run bit and clears the time-out flag.
// RQ18: External reset clears reload and prescaler, picks top tap, autoloads.
// RQ19: Underflow coinciding with external reset leaves the flag cleared.
// RQ20: After reset software should write reload first, then feed.
// RQ21: Software feeds within each time-out; avoid feeds in minor loops.
// RQ22: Underflow autoloads, sets flag, keeps run, reload and tap.
// RQ23: Control holds select in 7:5, run in 2, flag in 1.
// RQ24: Software clears the time-out flag by writing control.
// RQ25: With run bit clear, prescaler and counter hold, no reset; a broken feed sequence still requests reset here.
module watchdog_feed_reset_timer
  import wd_pkg::*;
#(
  parameter int unsigned RELOAD_W = COUNT_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              timer_tick_clock,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [APB_DW-1:0] pwdata,
  output logic      [APB_DW-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   wd_reset_out,
  output logic                   wd_running
);
  // Bus phases
  logic                  setup_phase;
  logic                  access_phase;
  logic                  wr_access;

  // Address decode
  logic                  hit_control;
  logic                  hit_reload;
  logic                  hit_feed_first;
  logic                  hit_feed_second;
  logic                  hit_status;
  logic                  hit_pending;
  logic                  hit_any;

  // Write strobes
  logic                  wr_control;
  logic                  wr_reload;

  // Committed control state
  logic [SEL_W-1:0]      sel_q;
  logic [SEL_W-1:0]      sel_d;
  logic                  run_q;
  logic                  run_d;
  logic                  tof_q;
  logic                  tof_d;

  // Pending control written by software
  logic [7:0]            pend_q;
  logic [7:0]            pend_d;

  // Autoload value and main counter
  logic [RELOAD_W-1:0]   reload_q;
  logic [RELOAD_W-1:0]   reload_d;
  logic [RELOAD_W-1:0]   count_q;
  logic [RELOAD_W-1:0]   count_d;

  // Reset request stretcher
  logic [3:0]            rst_cnt_q;
  logic [3:0]            rst_cnt_d;
  logic                  rst_out_q;
  logic                  rst_out_d;

  // Read path
  logic [APB_DW-1:0]     rdata_mux;
  logic [APB_DW-1:0]     prdata_q;
  logic                  slverr_q;

  // Event terms
  logic                  tap_pulse;
  logic                  underflow;
  logic                  feed_ok;
  logic                  feed_fault;
  logic                  feed_armed;
  logic                  wd_event;
  logic                  autoload;
  logic                  tof_clear;
  logic [PRESCALE_W-1:0] prescale_count;
  logic [7:0]            control_view;

  // Phase decode
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_access    = access_phase & pwrite;

  // Register decode
  assign hit_control     = (paddr == OFS_CONTROL);
  assign hit_reload      = (paddr == OFS_RELOAD);
  assign hit_feed_first  = (paddr == OFS_FEED_FIRST);
  assign hit_feed_second = (paddr == OFS_FEED_SECOND);
  assign hit_status      = (paddr == OFS_STATUS);
  assign hit_pending     = (paddr == OFS_PENDING);
  assign hit_any         = hit_control | hit_reload | hit_feed_first |
                           hit_feed_second | hit_status | hit_pending;

  assign wr_control = wr_access & hit_control;
  assign wr_reload  = wr_access & hit_reload;

  // Prescaler and tap
  wd_prescaler #(
    .WIDTH (PRESCALE_W)
  ) u_prescaler (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick      (timer_tick_clock), // RQ4
    .run       (run_q), // RQ25
    .clear     (autoload), // RQ7
    .sel       (sel_q),
    .tap_pulse (tap_pulse),
    .count     (prescale_count)
  ); // RQ3

  // Feed key sequence; every completed access is seen
  wd_feed_guard u_feed_guard (
    .pclk       (pclk),
    .presetn    (presetn),
    .access     (access_phase),
    .write      (pwrite),
    .hit_first  (hit_feed_first),
    .hit_second (hit_feed_second),
    .wdata      (pwdata[7:0]),
    .feed_ok    (feed_ok),
    .feed_fault (feed_fault),
    .armed      (feed_armed)
  ); // RQ10 RQ11 RQ12

  // Underflow and reset causes
  assign underflow = tap_pulse & (count_q == '0); // RQ6 RQ25
  assign wd_event  = underflow | feed_fault; // RQ1 RQ11 RQ12
  assign autoload  = wd_event | feed_ok; // RQ6 RQ7 RQ9
  assign tof_clear = wr_control & ~pwdata[TOF_BIT]; // RQ24

  // Pending control, writable bits only
  assign pend_d = wr_control ? (pwdata[7:0] & CONTROL_WMASK) : pend_q; // RQ13 RQ14

  // Committed control changes only on a valid feed
  assign sel_d = feed_ok ? pend_q[SEL_HI:SEL_LO] : sel_q; // RQ13 RQ22
  assign run_d = feed_ok ? pend_q[RUN_BIT] : run_q; // RQ13 RQ2 RQ22

  // Set wins over software clear
  assign tof_d = wd_event ? 1'b1 : (tof_clear ? 1'b0 : tof_q); // RQ22 RQ24

  // Autoload register written directly by software
  assign reload_d = wr_reload ? pwdata[RELOAD_W-1:0] : reload_q; // RQ7 RQ20 RQ22

  // Main counter loads only from autoload
  always_comb begin
    count_d = count_q;
    if (autoload) begin
      count_d = reload_q; // RQ6 RQ9 RQ10
    end else if (tap_pulse) begin
      count_d = count_q - 1'b1; // RQ5 RQ8
    end
  end

  // Reset request stretcher
  always_comb begin
    rst_cnt_d = rst_cnt_q;
    if (wd_event) begin
      rst_cnt_d = RESET_PULSE_CNT; // RQ1
    end else if (rst_cnt_q != 4'h0) begin
      rst_cnt_d = rst_cnt_q - 4'h1;
    end
  end

  // Control register image
  assign control_view = {sel_q, 2'b00, run_q, tof_q, 1'b0}; // RQ23

  // Read data select
  always_comb begin
    rdata_mux = '0;
    if (hit_control) begin
      rdata_mux[7:0] = control_view;
    end else if (hit_reload) begin
      rdata_mux[RELOAD_W-1:0] = reload_q;
    end else if (hit_status) begin
      rdata_mux[RELOAD_W-1:0]                      = count_q;
      rdata_mux[STAT_PRE_LO+PRESCALE_W-1:STAT_PRE_LO] = prescale_count;
      rdata_mux[STAT_ARMED_BIT]                    = feed_armed;
    end else if (hit_pending) begin
      rdata_mux[7:0] = pend_q;
    end
  end

  // Bus answer registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup_phase) begin
      prdata_q <= pwrite ? '0 : rdata_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slverr_q <= 1'b0;
    end else if (setup_phase) begin
      slverr_q <= ~hit_any;
    end
  end

  assign pready  = access_phase;
  assign pslverr = access_phase & slverr_q;
  assign prdata  = prdata_q;

  // Control and status registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= SEL_RESET; // RQ18 RQ23
    end else begin
      sel_q <= sel_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= RUN_RESET; // RQ2 RQ17
    end else begin
      run_q <= run_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tof_q <= 1'b0; // RQ17 RQ19
    end else begin
      tof_q <= tof_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= {SEL_RESET, 2'b00, RUN_RESET, 2'b00};
    end else begin
      pend_q <= pend_d;
    end
  end

  // Autoload value and counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= RELOAD_RESET; // RQ18
    end else begin
      reload_q <= reload_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= RELOAD_RESET; // RQ16 RQ18
    end else begin
      count_q <= count_d;
    end
  end

  // Reset request output
  assign rst_out_d = (rst_cnt_d != 4'h0); // RQ1

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_q <= 4'h0;
    end else begin
      rst_cnt_q <= rst_cnt_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_out_q <= 1'b0;
    end else begin
      rst_out_q <= rst_out_d; // RQ1
    end
  end

  assign wd_reset_out = rst_out_q;
  assign wd_running   = run_q;
endmodule

//--- wd_chk.sv
// Port assertions for the watchdog block
`timescale 1ns/1ps
module wd_chk
  import wd_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              timer_tick_clock,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  input wire logic [APB_DW-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              wd_reset_out,
  input wire logic              wd_running
);
  logic armed_q;
  logic armed_d;
  logic fault_q;
  wire  acc  = psel & penable & pready;
  wire  good = acc & pwrite & (paddr == OFS_FEED_SECOND) & (pwdata[7:0] == KEY_SECOND);
  wire  arm  = acc & pwrite & (paddr == OFS_FEED_FIRST) & (pwdata[7:0] == KEY_FIRST);
  assign armed_d = acc ? (arm & ~armed_q) : armed_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
      fault_q <= armed_q & acc & ~good;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pulse;
    wd_reset_out [*4] ##1 !wd_reset_out;
  endsequence
  AST_PULSE: assert property ($rose(wd_reset_out) |-> s_pulse)
    else $error("reset pulse length wrong");
  AST_FAULT: assert property (armed_q && acc && !good |-> ##[1:2] wd_reset_out)
    else $error("broken feed gave no reset");
  AST_FEED_OK: assert property (armed_q && good && !wd_reset_out |-> ##2 !wd_reset_out)
    else $error("valid feed gave a reset");
  AST_COMMIT: assert property ($changed(wd_running) |-> $past(armed_q && good))
    else $error("run bit changed without feed");
  AST_STOPPED: assert property ($rose(wd_reset_out) |-> wd_running || $past(wd_running)
    || $past(wd_running, 2) || fault_q || $past(fault_q)) else $error("reset while stopped");
  AST_BOOT: assert property ($rose(presetn) |-> wd_running && !wd_reset_out)
    else $error("bad state after reset");
  AST_CTRL_RD: assert property (acc && !pwrite && paddr == OFS_CONTROL |-> prdata[RUN_BIT] == wd_running)
    else $error("control read run bit wrong");
  AST_KEY_RD: assert property (acc && !pwrite && paddr == OFS_FEED_FIRST |-> prdata == '0)
    else $error("key register read not zero");
endmodule
bind watchdog_feed_reset_timer wd_chk u_wd_chk (.pclk(pclk), .presetn(presetn), .timer_tick_clock(timer_tick_clock),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .wd_reset_out(wd_reset_out), .wd_running(wd_running));

//--- watchdog_feed_reset_timer_bench.sv
// Self-checking bench for the watchdog block
`timescale 1ns/1ps
module watchdog_feed_reset_timer_bench
  import wd_pkg::*;
;
  logic        pclk = 0, presetn = 0, tick = 1, psel = 0, penable = 0, pwrite = 0, er, half = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, rst_o, run_o;
  int          n_mismatch = 0, comparisons = 0, cyc = 0, n_rise = 0, m;
  always #2 pclk = ~pclk;
  always @(posedge rst_o) n_rise++;
  always @(posedge pclk) if (half) tick <= ~tick;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      complete_run();
    end
  end
  watchdog_feed_reset_timer u_watchdog_feed_reset_timer (.pclk(pclk), .presetn(presetn), .timer_tick_clock(tick),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wd_reset_out(rst_o), .wd_running(run_o));
  task complete_run();
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic feed();
    apb(1'b1, OFS_FEED_FIRST, {24'h0, KEY_FIRST});
    apb(1'b1, OFS_FEED_SECOND, {24'h0, KEY_SECOND});
  endtask
  task automatic wait_rise(int e);
    while (rst_o !== 1'b1 && cyc - m < e + 50) @(posedge pclk);
    check("period", 32'(cyc - m >= e && cyc - m <= e + 4), 32'h1);
    repeat (8) @(posedge pclk);
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    m = cyc;
  endtask
  task automatic t_default();
    do_reset();
    apb(1'b0, OFS_CONTROL, 32'h0);
    check("control", rd, 32'hE4);
    apb(1'b0, OFS_RELOAD, 32'h0);
    check("reload", rd, 32'h0);
    wait_rise(4096);
    apb(1'b0, OFS_CONTROL, 32'h0);
    check("flag set", rd, 32'hE6);
    apb(1'b1, OFS_CONTROL, 32'hE4);
    apb(1'b0, OFS_CONTROL, 32'h0);
    check("flag clear", rd, 32'hE4);
  endtask
  task automatic t_select();
    logic [2:0] s;
    logic [7:0] w;
    for (int i = 0; i < 9; i++) begin
      s = 3'(i);
      w = (i == 8) ? 8'h02 : 8'h00;
      apb(1'b1, OFS_RELOAD, {24'h0, w});
      apb(1'b1, OFS_CONTROL, {24'h0, s, 5'h04});
      apb(1'b0, OFS_CONTROL, 32'h0);
      check("pending", rd[7:5], 32'(3'(s - 3'h1)));
      apb(1'b0, OFS_PENDING, 32'h0);
      check("pending word", rd, {24'h0, s, 5'h04});
      feed();
      m = cyc;
      apb(1'b0, OFS_CONTROL, 32'h0);
      check("committed", rd[7:5], 32'(s));
      wait_rise((w + 1) * (32 << s));
    end
  endtask
  task automatic bad_case(logic [7:0] k1, logic wr, logic [7:0] a, logic [7:0] d, int e);
    int r;
    feed();
    r = n_rise;
    apb(1'b1, OFS_FEED_FIRST, {24'h0, k1});
    apb(wr, a, {24'h0, d});
    repeat (4) @(posedge pclk);
    check("fault", n_rise - r, e);
    check("slverr", er, 32'(a == 8'h18));
    repeat (8) @(posedge pclk);
  endtask
  task automatic t_disable();
    logic [31:0] s0;
    int r;
    apb(1'b1, OFS_CONTROL, 32'h0);
    feed();
    @(posedge pclk);
    check("run off", run_o, 32'h0);
    r = n_rise;
    apb(1'b0, OFS_STATUS, 32'h0);
    s0 = rd;
    check("status", s0, 32'h2);
    apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
    repeat (300) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("frozen", rd, s0);
    check("quiet", n_rise - r, 32'h0);
  endtask
  task automatic t_rerun();
    do_reset();
    @(posedge pclk);
    check("run on", run_o, 32'h1);
    apb(1'b0, OFS_CONTROL, 32'h0);
    check("control", rd, 32'hE4);
    apb(1'b1, OFS_CONTROL, 32'h04);
    feed();
    m = cyc;
    half <= 1'b1;
    wait_rise(64);
  endtask
  initial begin
    t_default();
    t_select();
    bad_case(KEY_FIRST, 1'b1, OFS_FEED_SECOND, 8'h5B, 1);
    bad_case(KEY_FIRST, 1'b0, OFS_FEED_FIRST, 8'h00, 1);
    bad_case(KEY_FIRST, 1'b0, 8'h18, 8'h00, 1);
    bad_case(8'h12, 1'b1, OFS_FEED_SECOND, KEY_SECOND, 0);
    t_disable();
    t_rerun();
    complete_run();
  end
endmodule
